//--- common/asds_pkg.sv
// Shared constants and types for the conversion sequence and diagnostic select block.
// Assumes a 16-bit register port and a converter that pulses done once per conversion.
package asds_pkg;

   // Register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // Register offsets
   localparam logic [7:0] ADDR_CONV_CONTROL = 8'h23;
   localparam logic [7:0] ADDR_DIAG_SOURCE_SELECT = 8'h24;
   localparam logic [7:0] ADDR_SEQ_STATUS = 8'h30;

   // Reset values
   localparam logic [15:0] CONV_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] DIAG_SOURCE_SELECT_RESET = 16'h0000;

   // Conversion control fields
   localparam logic [15:0] CONV_CONTROL_WRITE_MASK = 16'h07ff;
   localparam int CTRL_REJECT_BIT = 10;
   localparam int CTRL_SEQ_LSB = 8;
   localparam int CTRL_SEQ_W = 2;
   localparam int CTRL_ENABLE_LSB = 0;
   localparam int CTRL_ENABLE_W = 8;
   localparam int INPUT_A_ENABLE_BIT = 0;
   localparam int INPUT_D_ENABLE_BIT = 3;
   localparam int DIAG_SLOT0_ENABLE_BIT = 4;
   localparam int DIAG_SLOT2_ENABLE_BIT = 6;

   // Diagnostic source select fields
   localparam int SEL_W = 4;
   localparam int SLOT0_SOURCE_LSB = 0;
   localparam int SLOT1_SOURCE_LSB = 4;
   localparam int SLOT2_SOURCE_LSB = 8;
   localparam int SLOT3_SOURCE_LSB = 12;
   localparam int NUM_DIAG_SLOTS = 4;

   // Sequence status fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STOP_BIT = 1;
   localparam int STAT_SLOT_LSB = 2;

   // Slot numbering: inputs A to D are 0 to 3, diagnostic slots 0 to 3 are 4 to 7
   localparam int NUM_SLOTS = 8;
   localparam int SLOT_W = 3;
   localparam logic [2:0] LAST_SLOT = 3'h7;

   // Diagnostic source codes
   localparam int NUM_SOURCES = 14;
   localparam logic [3:0] SRC_ANALOG_GROUND = 4'h0;
   localparam logic [3:0] SRC_TEMP_SENSOR = 4'h1;
   localparam logic [3:0] SRC_ANALOG_SUPPLY = 4'h2;
   localparam logic [3:0] SRC_NEGATIVE_PUMP_RAIL = 4'h3;
   localparam logic [3:0] SRC_REFERENCE_OUTPUT = 4'h4;
   localparam logic [3:0] SRC_ANALOG_REGULATOR_5V = 4'h5;
   localparam logic [3:0] SRC_ANALOG_REGULATOR_1V8 = 4'h6;
   localparam logic [3:0] SRC_DIGITAL_REGULATOR_1V8 = 4'h7;
   localparam logic [3:0] SRC_DIGITAL_CORE_SUPPLY = 4'h8;
   localparam logic [3:0] SRC_INTERFACE_SUPPLY = 4'h9;
   localparam logic [3:0] SRC_SENSE_A = 4'ha;
   localparam logic [3:0] SRC_SENSE_B = 4'hb;
   localparam logic [3:0] SRC_SENSE_C = 4'hc;
   localparam logic [3:0] SRC_SENSE_D = 4'hd;
   localparam logic [13:0] ROUTE_GROUND = 14'h0001;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_SINGLE = 2'b01,
      SEQ_CONTINUOUS = 2'b10,
      SEQ_POWER_DOWN = 2'b11
   } asds_seq_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } asds_bus_req_type;

   typedef struct packed {
      logic start;
      logic [SLOT_W-1:0] slot;
      logic [NUM_SOURCES-1:0] route;
   } asds_conv_cmd_type;

endpackage

//--- hw/asds_slot_decode.sv
// Decoder from one diagnostic selector code to a one-hot analog mux route.
// Assumes the selector is a stable register; output is combinational.
`timescale 1ns/1ps
module asds_slot_decode #(
   parameter int SW = asds_pkg::SEL_W,
   parameter int NS = asds_pkg::NUM_SOURCES
) (
   input wire logic [SW-1:0] sel,
   output logic [NS-1:0] route
);
   import asds_pkg::*;

   always_comb begin
      route = '0;
      case (sel)
         SRC_ANALOG_GROUND: route[SRC_ANALOG_GROUND] = 1'b1; // [R5]
         SRC_TEMP_SENSOR: route[SRC_TEMP_SENSOR] = 1'b1; // [R5]
         SRC_ANALOG_SUPPLY: route[SRC_ANALOG_SUPPLY] = 1'b1; // [R5]
         SRC_NEGATIVE_PUMP_RAIL: route[SRC_NEGATIVE_PUMP_RAIL] = 1'b1; // [R5]
         SRC_REFERENCE_OUTPUT: route[SRC_REFERENCE_OUTPUT] = 1'b1; // [R5]
         SRC_ANALOG_REGULATOR_5V: route[SRC_ANALOG_REGULATOR_5V] = 1'b1; // [R6]
         SRC_ANALOG_REGULATOR_1V8: route[SRC_ANALOG_REGULATOR_1V8] = 1'b1; // [R6]
         SRC_DIGITAL_REGULATOR_1V8: route[SRC_DIGITAL_REGULATOR_1V8] = 1'b1; // [R6]
         SRC_DIGITAL_CORE_SUPPLY: route[SRC_DIGITAL_CORE_SUPPLY] = 1'b1; // [R6]
         SRC_INTERFACE_SUPPLY: route[SRC_INTERFACE_SUPPLY] = 1'b1; // [R6]
         SRC_SENSE_A: route[SRC_SENSE_A] = 1'b1; // [R7]
         SRC_SENSE_B: route[SRC_SENSE_B] = 1'b1; // [R7]
         SRC_SENSE_C: route[SRC_SENSE_C] = 1'b1; // [R7]
         SRC_SENSE_D: route[SRC_SENSE_D] = 1'b1; // [R7]
         default: route[SRC_ANALOG_GROUND] = 1'b1; // [R8]
      endcase
   end

endmodule

//--- hw/asds_top.sv
// Conversion sequencer control with per-slot enables and diagnostic source routing.
// Assumes a single converter that takes one start pulse and answers with one done pulse.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

// How it works
// [R1] Diagnostic slots 2, 1, 0 convert only when control bits 6, 5, 4 are set.
// [R2] Inputs D, C, B, A convert only when control bits 3 to 0 are set.
// [R3] Source select register at 0x24, reset 0x0000, four 4-bit selectors.
// [R4] Bits 15:12 pick the source of diagnostic slot 3, result bit 3.
// [R5] Codes 0 to 4: ground, temperature, analog supply, pump rail, reference.
// [R6] Codes 5 to 9: regulators 5V, 1V8 analog, 1V8 digital, core, interface supply.
// [R7] Codes 10 to 13 pick the low-side sense pin of input A to D.
// [R8] Codes 14 and 15 fall back to analog ground.
// [R9] Bits 11:8 pick the source of diagnostic slot 2, same codes.
// [R10] Bits 7:4 and 3:0 pick the sources of slots 1 and 0.
// [R11] Sequence code 01 converts each enabled slot once, then stops.
// [R12] Software keeps enables still during a continuous run, code 10.
// [R13] A changed selector affects only the next conversion of that slot.
module asds_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire asds_pkg::asds_bus_req_type bus_req,
   output logic [asds_pkg::DATA_W-1:0] rd_data,
   input wire logic conv_done,
   output asds_pkg::asds_conv_cmd_type conv_cmd,
   output logic rejection_enable,
   output logic power_down,
   output logic seq_busy
);
   import asds_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PICK = 3'b010,
      ST_CONVERT = 3'b100
   } asds_state_type;

   asds_state_type state;
   logic [DATA_W-1:0] conv_control;
   logic [DATA_W-1:0] diag_source_select;
   logic [SLOT_W-1:0] slot_index;
   logic [NUM_SLOTS-1:0] run_enable;
   logic stop_req;
   logic [NUM_DIAG_SLOTS-1:0][NUM_SOURCES-1:0] slot_route;

   logic ctrl_write;
   logic select_write;
   asds_seq_type new_seq;
   logic start_req;
   logic stop_write;
   logic continuous;
   logic last_slot;
   logic launch;
   logic [SLOT_W-1:0] next_slot;

   // Bus decode
   assign ctrl_write = bus_req.wr && (bus_req.addr == ADDR_CONV_CONTROL);
   assign select_write = bus_req.wr && (bus_req.addr == ADDR_DIAG_SOURCE_SELECT);
   assign new_seq = asds_seq_type'(bus_req.wdata[CTRL_SEQ_LSB +: CTRL_SEQ_W]);

   // Starts are taken only when the sequencer is idle
   assign start_req = ctrl_write && (state == ST_IDLE) &&
                      ((new_seq == SEQ_SINGLE) || (new_seq == SEQ_CONTINUOUS));
   assign stop_write = ctrl_write && ((new_seq == SEQ_IDLE) || (new_seq == SEQ_POWER_DOWN));
   assign continuous = (conv_control[CTRL_SEQ_LSB +: CTRL_SEQ_W] == SEQ_CONTINUOUS);
   assign last_slot = (slot_index == LAST_SLOT);
   assign next_slot = slot_index + 3'h1;
   assign launch = (state == ST_PICK) && !stop_req && run_enable[slot_index]; // [R1] [R2]

   // Conversion control register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv_control <= CONV_CONTROL_RESET;
      end else if (ctrl_write) begin
         conv_control <= bus_req.wdata & CONV_CONTROL_WRITE_MASK; // [R1] [R2]
      end
   end

   // Side outputs mirroring the control register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rejection_enable <= 1'b0;
         power_down <= 1'b0;
      end else if (ctrl_write) begin
         rejection_enable <= bus_req.wdata[CTRL_REJECT_BIT];
         power_down <= (new_seq == SEQ_POWER_DOWN);
      end
   end

   // Diagnostic source select register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         diag_source_select <= DIAG_SOURCE_SELECT_RESET; // [R3]
      end else if (select_write) begin
         diag_source_select <= bus_req.wdata; // [R3]
      end
   end

   // One decoder per diagnostic slot
   for (genvar g = 0; g < NUM_DIAG_SLOTS; g++) begin : gen_decode
      asds_slot_decode #(
         .SW(SEL_W),
         .NS(NUM_SOURCES)
      ) u_decode (
         .sel(diag_source_select[g*SEL_W +: SEL_W]), // [R4] [R9] [R10]
         .route(slot_route[g])
      );
   end

   // Stop request; a stop write sets it outside idle, and idle clears it and ignores a stop write
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stop_req <= 1'b0;
      end else if (stop_write && (state != ST_IDLE)) begin
         stop_req <= 1'b1;
      end else if (state == ST_IDLE) begin
         stop_req <= 1'b0;
      end
   end

   // Sequencer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         slot_index <= '0;
         run_enable <= '0;
         seq_busy <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_req) begin
                  state <= ST_PICK;
                  slot_index <= '0;
                  // Enables are frozen for the whole run
                  run_enable <= bus_req.wdata[CTRL_ENABLE_LSB +: CTRL_ENABLE_W]; // [R12]
                  seq_busy <= 1'b1;
               end
            end
            ST_PICK: begin
               if (stop_req) begin
                  state <= ST_IDLE;
                  seq_busy <= 1'b0;
               end else if (run_enable[slot_index]) begin
                  state <= ST_CONVERT; // [R1] [R2]
               end else if (!last_slot) begin
                  slot_index <= next_slot;
               end else if (continuous) begin
                  slot_index <= '0;
               end else begin
                  state <= ST_IDLE; // [R11]
                  seq_busy <= 1'b0;
               end
            end
            ST_CONVERT: begin
               if (conv_done) begin
                  if (stop_req) begin
                     state <= ST_IDLE;
                     seq_busy <= 1'b0;
                  end else if (!last_slot) begin
                     state <= ST_PICK;
                     slot_index <= next_slot;
                  end else if (continuous) begin
                     state <= ST_PICK;
                     slot_index <= '0;
                  end else begin
                     state <= ST_IDLE; // [R11]
                     seq_busy <= 1'b0;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               seq_busy <= 1'b0;
            end
         endcase
      end
   end

   // Converter command; route is latched at launch and held through the conversion
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv_cmd <= '0;
      end else begin
         conv_cmd.start <= launch;
         if (launch) begin
            conv_cmd.slot <= slot_index;
            if (slot_index[2]) begin
               conv_cmd.route <= slot_route[slot_index[1:0]]; // [R13]
            end else begin
               conv_cmd.route <= '0;
            end
         end
      end
   end

   // Read data, valid in the cycle after the read strobe only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= '0;
         if (bus_req.rd) begin
            case (bus_req.addr)
               ADDR_CONV_CONTROL: rd_data <= conv_control;
               ADDR_DIAG_SOURCE_SELECT: rd_data <= diag_source_select; // [R3]
               ADDR_SEQ_STATUS: begin
                  rd_data[STAT_BUSY_BIT] <= seq_busy;
                  rd_data[STAT_STOP_BIT] <= stop_req;
                  rd_data[STAT_SLOT_LSB +: SLOT_W] <= slot_index;
               end
               default: rd_data <= '0;
            endcase
         end
      end
   end

   // Reference decode for checking
   function automatic logic [NUM_SOURCES-1:0] ref_route(input logic [SEL_W-1:0] code);
      logic [NUM_SOURCES-1:0] r;
      r = ROUTE_GROUND;
      if (code < 4'he) begin
         r = 14'h0001 << code;
      end
      return r;
   endfunction

   AST_DIAG_ENABLE_GATE: // [R1]
   assert property (@(posedge clock) disable iff (!rst_n)
      (conv_cmd.start && conv_cmd.slot[2]) |-> run_enable[conv_cmd.slot] && seq_busy)
      else $error("diagnostic slot converted while its enable was clear");

   AST_INPUT_ENABLE_GATE: // [R2]
   assert property (@(posedge clock) disable iff (!rst_n)
      (start_req && !bus_req.wdata[INPUT_A_ENABLE_BIT]) |=>
         (!(conv_cmd.start && conv_cmd.slot == 3'h0)) [*8])
      else $error("input A converted while its enable was clear");

   AST_SELECT_READBACK: // [R3]
   assert property (@(posedge clock) disable iff (!rst_n)
      (bus_req.rd && bus_req.addr == ADDR_DIAG_SOURCE_SELECT) |=>
         rd_data == $past(diag_source_select))
      else $error("source select readback mismatch");

   AST_SLOT3_ROUTE: // [R4]
   assert property (@(posedge clock) disable iff (!rst_n)
      (launch && slot_index == 3'h7) |=>
         conv_cmd.start && conv_cmd.route == ref_route($past(diag_source_select[15:12])))
      else $error("slot 3 route does not follow bits 15:12");

   AST_SENSE_PIN_ROUTE: // [R7]
   assert property (@(posedge clock) disable iff (!rst_n)
      (launch && slot_index[2] && diag_source_select[slot_index[1:0]*4 +: 4] == SRC_SENSE_C) |=>
         conv_cmd.route == 14'h1000)
      else $error("sense pin C code routed wrongly");

   AST_UNDEFINED_GROUND: // [R8]
   assert property (@(posedge clock) disable iff (!rst_n)
      (launch && slot_index[2] && diag_source_select[slot_index[1:0]*4 +: 4] >= 4'he) |=>
         conv_cmd.route == ROUTE_GROUND)
      else $error("undefined code did not route to ground");

   AST_SLOT2_ROUTE: // [R9]
   assert property (@(posedge clock) disable iff (!rst_n)
      (launch && slot_index == 3'h6) |=>
         conv_cmd.route == ref_route($past(diag_source_select[11:8])))
      else $error("slot 2 route does not follow bits 11:8");

   AST_SLOT1_0_ROUTE: // [R10]
   assert property (@(posedge clock) disable iff (!rst_n)
      (launch && (slot_index == 3'h5 || slot_index == 3'h4)) |=>
         conv_cmd.route == ref_route(slot_index[0] ? $past(diag_source_select[7:4])
                                                   : $past(diag_source_select[3:0])))
      else $error("slot 1 or 0 route does not follow its selector");

   AST_SINGLE_PASS_END: // [R11]
   assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_CONVERT && conv_done && last_slot && !continuous) |=>
         state == ST_IDLE && !seq_busy)
      else $error("single sequence did not end after last slot");

   AST_ENABLES_FROZEN: // [R12]
   assert property (@(posedge clock) disable iff (!rst_n)
      (seq_busy && $past(seq_busy)) |-> $stable(run_enable))
      else $error("enable snapshot changed during a run");

   AST_ROUTE_HELD: // [R13]
   assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_CONVERT && !conv_done) |=> $stable(conv_cmd.route) && !conv_cmd.start)
      else $error("route changed during a conversion");

   AST_START_ONE_CYCLE: // [R11]
   assert property (@(posedge clock) disable iff (!rst_n)
      conv_cmd.start |=> !conv_cmd.start)
      else $error("converter start lasted more than one cycle");

   AST_START_ACCEPTED: // [R11]
   assert property (@(posedge clock) disable iff (!rst_n)
      start_req |=> seq_busy && state == ST_PICK && slot_index == 3'h0)
      else $error("start write did not begin a sequence at slot 0");

   AST_INPUT_ROUTE_ZERO: // [R2]
   assert property (@(posedge clock) disable iff (!rst_n)
      (launch && !slot_index[2]) |=> conv_cmd.route == 14'h0000)
      else $error("input slot carried a diagnostic route");

   AST_ROUTE_ONE_HOT: // [R5]
   assert property (@(posedge clock) disable iff (!rst_n)
      (conv_cmd.start && conv_cmd.slot[2]) |-> $onehot(conv_cmd.route))
      else $error("diagnostic route is not one-hot");

   AST_SELECT_WRITE: // [R3]
   assert property (@(posedge clock) disable iff (!rst_n)
      select_write |=> diag_source_select == $past(bus_req.wdata))
      else $error("source select write did not land");

   AST_CONTROL_READBACK: // [R1]
   assert property (@(posedge clock) disable iff (!rst_n)
      (bus_req.rd && bus_req.addr == ADDR_CONV_CONTROL) |=> rd_data == $past(conv_control))
      else $error("control readback mismatch");

   AST_STATUS_READ: // [R11]
   assert property (@(posedge clock) disable iff (!rst_n)
      (bus_req.rd && bus_req.addr == ADDR_SEQ_STATUS) |=>
         rd_data[STAT_BUSY_BIT] == $past(seq_busy) && rd_data[STAT_SLOT_LSB +: SLOT_W] == $past(slot_index))
      else $error("status readback mismatch");

   AST_BUSY_WRITE_IGNORED: // [R12]
   assert property (@(posedge clock) disable iff (!rst_n)
      (ctrl_write && seq_busy) |=> $stable(run_enable))
      else $error("control write during a run changed the enable snapshot");

   AST_CONTINUOUS_WRAP: // [R12]
   assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_CONVERT && conv_done && last_slot && continuous && !stop_req) |=>
         state == ST_PICK && slot_index == 3'h0)
      else $error("continuous sequence did not wrap to slot 0");

   AST_STOP_ENDS_RUN: // [R12]
   assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_CONVERT && conv_done && stop_req) |=> state == ST_IDLE && !seq_busy)
      else $error("stop did not end the sequence after the conversion");

endmodule

//--- test/test_asds_top.sv
// Self-checking bench for the conversion sequence and diagnostic select block.
// Assumes the register port and converter handshake of asds_top, one clock, async reset.
`timescale 1ns/1ps
module test_asds_top;
   import asds_pkg::*;

   logic clock = 1'b0;
   logic rst_n = 1'b0;
   asds_bus_req_type bus_req = '0;
   logic conv_done = 1'b0;
   logic [DATA_W-1:0] rd_data;
   asds_conv_cmd_type conv_cmd;
   logic rejection_enable;
   logic power_down;
   logic seq_busy;
   int errors = 0;
   int checks = 0;
   int seed = 59;
   logic [15:0] sel_reg = 16'h0000;
   logic [15:0] rd_val;

   always #5 clock = ~clock;

   asds_top i_dut (
      .clock(clock),
      .rst_n(rst_n),
      .bus_req(bus_req),
      .rd_data(rd_data),
      .conv_done(conv_done),
      .conv_cmd(conv_cmd),
      .rejection_enable(rejection_enable),
      .power_down(power_down),
      .seq_busy(seq_busy)
   );

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask

   // Register read, data in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1;
      d = rd_data;
   endtask

   // Expected mux route for a slot and selector word
   function automatic logic [13:0] exp_route(input logic [2:0] slot, input logic [15:0] sel);
      int s;
      logic [3:0] code;
      s = slot;
      if (s < 4) begin
         return 14'h0000;
      end
      code = sel[4*(s-4) +: 4];
      if (code > 4'hd) begin
         return 14'h0001;
      end
      return 14'h0001 << code;
   endfunction

   task automatic wait_start(output bit got);
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge clock);
         #1;
         if (conv_cmd.start === 1'b1) begin
            break;
         end
      end
      got = (i < 40);
   endtask

   // Runs one sequence and answers every conversion
   task automatic run_seq(input logic [7:0] en, input logic [1:0] code, input int rounds, input bit mid);
      int n;
      int k;
      bit got;
      logic [13:0] held;
      logic [2:0] order[$];
      for (k = 0; k < rounds; k++) begin
         for (n = 0; n < 8; n++) begin
            if (en[n]) begin
               order.push_back(3'(n));
            end
         end
      end
      wr(ADDR_CONV_CONTROL, {6'h00, code, en});
      #1;
      check("busy after start", seq_busy, 1'b1);
      for (k = 0; k < order.size(); k++) begin
         wait_start(got);
         if (!got) begin
            errors++;
            end_of_test();
         end
         check("slot", conv_cmd.slot, order[k]);
         check("route", conv_cmd.route, exp_route(order[k], sel_reg));
         held = exp_route(order[k], sel_reg);
         if (mid && k == 0) begin
            rd(ADDR_SEQ_STATUS, rd_val);
            check("status busy", rd_val, {11'h000, order[k], 2'b01});
            sel_reg = ~sel_reg;
            wr(ADDR_DIAG_SOURCE_SELECT, sel_reg);
            #1;
            check("route held", conv_cmd.route, held);
         end
         if (code == SEQ_CONTINUOUS && k == 0) begin
            wr(ADDR_CONV_CONTROL, {6'h00, code, en});
         end
         if (code == SEQ_CONTINUOUS && k == order.size() - 1) begin
            wr(ADDR_CONV_CONTROL, {6'h00, 2'b00, en});
            rd(ADDR_SEQ_STATUS, rd_val);
            check("status stop", rd_val, {11'h000, order[k], 2'b11});
         end
         repeat (2'($random(seed))) @(posedge clock);
         @(posedge clock);
         conv_done <= 1'b1;
         @(posedge clock);
         conv_done <= 1'b0;
      end
      for (n = 0; n < 20 && seq_busy !== 1'b0; n++) begin
         @(posedge clock);
         #1;
         check("no extra start", conv_cmd.start, 1'b0);
      end
      check("busy at end", seq_busy, 1'b0);
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      end_of_test();
   end

   initial begin
      int c;
      logic [7:0] en;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      rd(ADDR_DIAG_SOURCE_SELECT, rd_val);
      check("select reset", rd_val, DIAG_SOURCE_SELECT_RESET);
      rd(ADDR_CONV_CONTROL, rd_val);
      check("control reset", rd_val, 16'h0000);
      wr(ADDR_CONV_CONTROL, 16'hf8ff);
      rd(ADDR_CONV_CONTROL, rd_val);
      check("enables rw", rd_val, 16'h00ff);
      wr(ADDR_CONV_CONTROL, 16'h0700);
      #1;
      check("rejection out", rejection_enable, 1'b1);
      check("power down out", power_down, 1'b1);
      rd(ADDR_CONV_CONTROL, rd_val);
      check("control upper bits", rd_val, 16'h0700);
      wr(ADDR_CONV_CONTROL, 16'h0000);
      rd(ADDR_CONV_CONTROL, rd_val);
      check("enables clear", rd_val, 16'h0000);
      check("rejection clear", rejection_enable, 1'b0);
      check("power down clear", power_down, 1'b0);
      rd(ADDR_SEQ_STATUS, rd_val);
      check("status idle", rd_val, 16'h0000);
      rd(8'h7f, rd_val);
      check("unmapped read", rd_val, 16'h0000);
      for (c = 0; c < 8; c++) begin
         sel_reg = $random(seed);
         wr(ADDR_DIAG_SOURCE_SELECT, sel_reg);
         rd(ADDR_DIAG_SOURCE_SELECT, rd_val);
         check("select rw", rd_val, sel_reg);
      end
      $display("test registers done");
      for (c = 0; c < 16; c++) begin
         sel_reg = {4'(c + 3), 4'(c + 2), 4'(c + 1), 4'(c)};
         wr(ADDR_DIAG_SOURCE_SELECT, sel_reg);
         run_seq(8'hf0, SEQ_SINGLE, 1, 1'b0);
      end
      $display("test all codes done");
      for (c = 0; c < 6; c++) begin
         sel_reg = $random(seed);
         en = $random(seed);
         if (en == 8'h00) begin
            en = 8'h81;
         end
         wr(ADDR_DIAG_SOURCE_SELECT, sel_reg);
         run_seq(en, SEQ_SINGLE, 1, 1'b0);
      end
      $display("test random single done");
      sel_reg = $random(seed);
      wr(ADDR_DIAG_SOURCE_SELECT, sel_reg);
      run_seq(8'h30, SEQ_SINGLE, 1, 1'b1);
      $display("test select change done");
      en = $random(seed);
      run_seq(en | 8'h81, SEQ_CONTINUOUS, 2, 1'b0);
      run_seq(8'h0c, SEQ_CONTINUOUS, 1, 1'b0);
      $display("test continuous done");
      end_of_test();
   end
endmodule
